// [rtl/banked_regs_exception_unit.sv]
// Mode-banked register file, status words, system coprocessor and exception entry
//
// Behaviour
// - Fast mode banks registers 8-14 plus saved status
// - Other privileged modes bank 13, 14, saved status
// - Interrupt link is next address plus four
// - Trap link is address plus four or two
// - Instruction abort plus four, data abort plus eight
// - Undefined link is address plus four or two
// - Program counter low bits read zero, ignore writes
// - Entry copies current status into target saved status
// - Flag bit on PC write restores status
// - Four condition flags in top status bits
// - Logical ops take shifter carry, keep overflow
// - Low byte: interrupt disables, narrow bit, mode
// - User mode cannot change control; unused read zero
// - Coprocessor register 11 captures multiply high word
// - Foreign coprocessor instructions raise an exception
// - Vectors for reset, undefined, trap, prefetch abort
// - Vectors for data abort and both interrupts
// - Reset halts at once, supervisor, vector zero
// - After reset: supervisor, address zero, interrupts off
// - Undefined on no coprocessor or reserved encoding
// - Undefined entry saves memory-stage address and status
// - Return moves link to PC, restores status
// - Interrupt inputs ignored while their disable set
// - Mode field decode including both user codes
// - Fixed priority among simultaneous exceptions
`timescale 1ns/1ns
module banked_regs_exception_unit import banked_regs_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_irq_req,
  input wire logic i_fiq_req,
  input wire logic i_data_abort,
  input wire logic i_prefetch_abort,
  input wire logic i_trap,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_cp_instr,
  input wire logic [3:0] i_cp_num,
  input wire logic [31:0] i_mem_pc,
  input wire logic [31:0] i_next_pc,
  input wire logic [3:0] i_rd_addr,
  input wire logic i_wr_en,
  input wire logic [3:0] i_wr_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr_restore,
  input wire logic i_pc_step,
  input wire logic i_flag_we,
  input wire logic i_logical_op,
  input wire logic [31:0] i_result,
  input wire logic i_alu_carry,
  input wire logic i_alu_ovf,
  input wire logic i_shift_carry,
  input wire logic i_status_we,
  input wire logic i_status_saved,
  input wire logic [31:0] i_status_data,
  input wire logic i_exc_return,
  input wire logic i_mul_valid,
  input wire logic [31:0] i_mul_hi,
  input wire logic i_cp_we,
  input wire logic i_cp_re,
  input wire logic [3:0] i_cp_reg,
  input wire logic [31:0] i_cp_wdata,
  output logic [31:0] o_rd_data,
  output logic [31:0] o_pc,
  output status_s o_status,
  output logic [31:0] o_saved_status,
  output logic [31:0] o_cp_rdata,
  output logic o_exc_taken,
  output exc_kind_e o_exc_kind,
  output logic [31:0] o_exc_vector
);

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  // Anything not privileged falls back to the user bank, including 5'h10 and 5'h1F
  function automatic logic [2:0] saved_slot(input logic [4:0] mode);
    case (mode)
      MODE_FIQ: saved_slot = SLOT_FIQ;
      MODE_IRQ: saved_slot = SLOT_IRQ;
      MODE_SVC: saved_slot = SLOT_SVC;
      MODE_ABT: saved_slot = SLOT_ABT;
      MODE_UND: saved_slot = SLOT_UND;
      default: saved_slot = SLOT_NONE;
    endcase
  endfunction : saved_slot

  function automatic logic [4:0] phys_idx(input logic [4:0] mode, input logic [3:0] r);
    logic [4:0] wide;
    logic [4:0] ofs;
    wide = {1'b0, r};
    case (mode)
      MODE_IRQ: ofs = OFS_IRQ;
      MODE_SVC: ofs = OFS_SVC;
      MODE_ABT: ofs = OFS_ABT;
      MODE_UND: ofs = OFS_UND;
      default: ofs = 5'h00;
    endcase
    if (mode == MODE_FIQ && r >= REG_FIQ_FIRST && r <= REG_LINK) begin
      phys_idx = wide + OFS_FIQ;
    end else if (ofs != 5'h00 && r >= REG_STACK && r <= REG_LINK) begin
      phys_idx = wide + ofs;
    end else begin
      phys_idx = wide;
    end
  endfunction : phys_idx

  function automatic logic [4:0] target_mode(input exc_kind_e kind);
    case (kind)
      EXC_FIQ: target_mode = MODE_FIQ;
      EXC_IRQ: target_mode = MODE_IRQ;
      EXC_DABT, EXC_PABT: target_mode = MODE_ABT;
      EXC_UNDEF: target_mode = MODE_UND;
      default: target_mode = MODE_SVC;
    endcase
  endfunction : target_mode

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [1:0] irq_sync_r, irq_sync_nxt;
  logic [1:0] fiq_sync_r, fiq_sync_nxt;
  logic [31:0] gpr_r [GPR_PHYS];
  logic [31:0] gpr_nxt [GPR_PHYS];
  logic [31:0] saved_r [SAVED_STATUS_WORD_SLOTS];
  logic [31:0] saved_nxt [SAVED_STATUS_WORD_SLOTS];
  status_s status_r, status_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic [31:0] mulhi_r, mulhi_nxt;
  logic [31:0] rd_data_r, rd_data_nxt;
  logic [31:0] saved_rd_r, saved_rd_nxt;
  logic [31:0] cp_rdata_r, cp_rdata_nxt;
  logic exc_taken_r, exc_taken_nxt;
  exc_kind_e exc_kind_r, exc_kind_nxt;
  logic [31:0] exc_vector_r, exc_vector_nxt;

  exc_req_s req;
  exc_kind_e kind;
  logic [2:0] cur_slot;
  logic [2:0] tgt_slot;
  logic [4:0] tgt_mode;
  logic privileged;
  logic [31:0] pc_mask;
  logic [31:0] pc_step;
  logic [31:0] link_val;
  logic [31:0] status_word;

  // ---------------------------------------------------------------------------
  // Request gathering
  // ---------------------------------------------------------------------------
  always_comb begin
    irq_sync_nxt = {irq_sync_r[0], i_irq_req};
    fiq_sync_nxt = {fiq_sync_r[0], i_fiq_req};
    req.irq = irq_sync_r[1] & ~status_r.irq_off;
    req.fast_interrupt = fiq_sync_r[1] & ~status_r.fiq_off;
    req.data_abort = i_data_abort;
    req.prefetch_abort = i_prefetch_abort;
    req.trap = i_trap;
    // Only the system coprocessor exists, so nobody answers any other number
    req.undef = i_instr_valid & ((i_instr[UNDEF_OPC_LSB +: 3] == UNDEF_OPC && i_instr[UNDEF_BIT])
                                 | (i_cp_instr && i_cp_num != CP_SYS_NUM));
  end

  exception_arbiter u_arbiter (
    .i_req(req),
    .o_kind(kind)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    gpr_nxt = gpr_r;
    saved_nxt = saved_r;
    status_nxt = status_r;
    pc_nxt = pc_r;
    mulhi_nxt = mulhi_r;
    exc_taken_nxt = 1'b0;
    exc_kind_nxt = EXC_NONE;
    exc_vector_nxt = exc_vector_r;
    cur_slot = saved_slot(status_r.mode);
    privileged = (cur_slot != SLOT_NONE);
    pc_mask = status_r.narrow ? PC_MASK_NARROW : PC_MASK_WIDE;
    pc_step = status_r.narrow ? PC_STEP_NARROW : PC_STEP_WIDE;
    tgt_mode = target_mode(kind);
    tgt_slot = saved_slot(tgt_mode);
    link_val = '0;
    status_word = 32'h0000_0000;

    // Read ports; user mode has no saved word and reads it as zero
    rd_data_nxt = (i_rd_addr == REG_PC) ? (pc_r & pc_mask) : gpr_r[phys_idx(status_r.mode, i_rd_addr)];
    saved_rd_nxt = privileged ? saved_r[cur_slot] : 32'h0000_0000;
    cp_rdata_nxt = cp_rdata_r;
    if (i_cp_re && i_cp_num == CP_SYS_NUM) begin
      cp_rdata_nxt = (i_cp_reg == CP_MULHI_REG) ? mulhi_r : 32'h0000_0000;
    end

    // Sequential fetch advance
    if (i_pc_step) begin
      pc_nxt = pc_r + pc_step;
    end

    // Condition flags
    if (i_flag_we) begin
      status_nxt.n = i_result[31];
      status_nxt.z = (i_result == 32'h0000_0000);
      status_nxt.c = i_logical_op ? i_shift_carry : i_alu_carry;
      if (!i_logical_op) begin
        status_nxt.v = i_alu_ovf;
      end
    end

    // Explicit status writes
    if (i_status_we) begin
      status_word = i_status_data & STATUS_USED_MASK;
      if (i_status_saved) begin
        if (privileged) begin
          saved_nxt[cur_slot] = status_word;
        end
      end else if (privileged) begin
        status_nxt = status_s'(status_word);
      end else begin
        status_nxt = status_s'((status_word & STATUS_FLAG_MASK) | (32'(status_r) & ~STATUS_FLAG_MASK));
      end
    end

    // Writeback port
    if (i_wr_en) begin
      if (i_wr_addr == REG_PC) begin
        pc_nxt = i_wr_data & pc_mask;
        if (i_wr_restore && privileged) begin
          status_nxt = status_s'(saved_r[cur_slot] & STATUS_USED_MASK);
        end
      end else begin
        gpr_nxt[phys_idx(status_r.mode, i_wr_addr)] = i_wr_data;
      end
    end

    // Exception return
    if (i_exc_return && privileged) begin
      pc_nxt = gpr_r[phys_idx(status_r.mode, REG_LINK)] & pc_mask;
      status_nxt = status_s'(saved_r[cur_slot] & STATUS_USED_MASK);
    end

    // Multiply capture beats a coprocessor write in the same cycle
    if (i_cp_we && i_cp_num == CP_SYS_NUM && i_cp_reg == CP_MULHI_REG) begin
      mulhi_nxt = i_cp_wdata;
    end
    if (i_mul_valid) begin
      mulhi_nxt = i_mul_hi;
    end

    // Exception entry; the writeback-stage work above is allowed to finish first
    if (kind != EXC_NONE) begin
      case (kind)
        EXC_FIQ, EXC_IRQ: begin
          link_val = i_next_pc + LINK_OFS_4;
          exc_vector_nxt = (kind == EXC_FIQ) ? VEC_FIQ : VEC_IRQ;
        end
        EXC_TRAP: begin
          link_val = i_mem_pc + (status_r.narrow ? LINK_OFS_2 : LINK_OFS_4);
          exc_vector_nxt = VEC_TRAP;
        end
        EXC_PABT: begin
          link_val = i_mem_pc + LINK_OFS_4;
          exc_vector_nxt = VEC_PABT;
        end
        EXC_DABT: begin
          link_val = i_mem_pc + LINK_OFS_8;
          exc_vector_nxt = VEC_DABT;
        end
        EXC_UNDEF: begin
          link_val = i_mem_pc + (status_r.narrow ? LINK_OFS_2 : LINK_OFS_4);
          exc_vector_nxt = VEC_UNDEF;
        end
        default: begin
          link_val = '0;
          exc_vector_nxt = VEC_RESET;
        end
      endcase
      gpr_nxt[phys_idx(tgt_mode, REG_LINK)] = link_val;
      saved_nxt[tgt_slot] = 32'(status_nxt) & STATUS_USED_MASK;
      status_nxt.mode = tgt_mode;
      status_nxt.narrow = 1'b0;
      status_nxt.irq_off = 1'b1;
      if (kind == EXC_FIQ) begin
        status_nxt.fiq_off = 1'b1;
      end
      pc_nxt = exc_vector_nxt;
      exc_taken_nxt = 1'b1;
      exc_kind_nxt = kind;
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  // Reset is asynchronous so execution stops at once, whatever the pipeline holds
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_sync_r <= 2'h0;
      fiq_sync_r <= 2'h0;
      for (int k = 0; k < GPR_PHYS; k++) begin
        gpr_r[k] <= 32'h0000_0000;
      end
      for (int k = 0; k < SAVED_STATUS_WORD_SLOTS; k++) begin
        saved_r[k] <= 32'h0000_0000;
      end
      status_r <= STATUS_RESET;
      pc_r <= PC_RESET;
      mulhi_r <= 32'h0000_0000;
      rd_data_r <= 32'h0000_0000;
      saved_rd_r <= 32'h0000_0000;
      cp_rdata_r <= 32'h0000_0000;
      exc_taken_r <= 1'b0;
      exc_kind_r <= EXC_RESET;
      exc_vector_r <= VEC_RESET;
    end else begin
      irq_sync_r <= irq_sync_nxt;
      fiq_sync_r <= fiq_sync_nxt;
      gpr_r <= gpr_nxt;
      saved_r <= saved_nxt;
      status_r <= status_nxt;
      pc_r <= pc_nxt;
      mulhi_r <= mulhi_nxt;
      rd_data_r <= rd_data_nxt;
      saved_rd_r <= saved_rd_nxt;
      cp_rdata_r <= cp_rdata_nxt;
      exc_taken_r <= exc_taken_nxt;
      exc_kind_r <= exc_kind_nxt;
      exc_vector_r <= exc_vector_nxt;
    end
  end

  assign o_rd_data = rd_data_r;
  assign o_pc = pc_r;
  assign o_status = status_r;
  assign o_saved_status = saved_rd_r;
  assign o_cp_rdata = cp_rdata_r;
  assign o_exc_taken = exc_taken_r;
  assign o_exc_kind = exc_kind_r;
  assign o_exc_vector = exc_vector_r;

endmodule : banked_regs_exception_unit

// [rtl/banked_regs_pkg.sv]
// Constants, types and field layouts shared by the banked register / exception unit
package banked_regs_pkg;

  // ---------------------------------------------------------------------------
  // Mode field encodings
  // ---------------------------------------------------------------------------
  localparam logic [4:0] MODE_USR = 5'h10;
  localparam logic [4:0] MODE_FIQ = 5'h11;
  localparam logic [4:0] MODE_IRQ = 5'h12;
  localparam logic [4:0] MODE_SVC = 5'h13;
  localparam logic [4:0] MODE_ABT = 5'h17;
  localparam logic [4:0] MODE_UND = 5'h1B;
  localparam logic [4:0] MODE_SYS = 5'h1F;

  // ---------------------------------------------------------------------------
  // Exception vectors
  // ---------------------------------------------------------------------------
  localparam logic [31:0] VEC_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
  localparam logic [31:0] VEC_PABT = 32'h0000_000C;
  localparam logic [31:0] VEC_DABT = 32'h0000_0010;
  localparam logic [31:0] VEC_RSVD = 32'h0000_0014;
  localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
  localparam logic [31:0] VEC_FIQ = 32'h0000_001C;

  // ---------------------------------------------------------------------------
  // Link offsets, program counter steps and masks
  // ---------------------------------------------------------------------------
  localparam logic [31:0] LINK_OFS_2 = 32'h0000_0002;
  localparam logic [31:0] LINK_OFS_4 = 32'h0000_0004;
  localparam logic [31:0] LINK_OFS_8 = 32'h0000_0008;
  localparam logic [31:0] PC_STEP_WIDE = 32'h0000_0004;
  localparam logic [31:0] PC_STEP_NARROW = 32'h0000_0002;
  localparam logic [31:0] PC_MASK_WIDE = 32'hFFFF_FFFC;
  localparam logic [31:0] PC_MASK_NARROW = 32'hFFFF_FFFE;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Register file geometry
  // ---------------------------------------------------------------------------
  localparam int GPR_PHYS = 30;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [3:0] REG_LINK = 4'hE;
  localparam logic [3:0] REG_STACK = 4'hD;
  localparam logic [3:0] REG_FIQ_FIRST = 4'h8;
  localparam logic [4:0] OFS_FIQ = 5'h07;
  localparam logic [4:0] OFS_IRQ = 5'h09;
  localparam logic [4:0] OFS_SVC = 5'h0B;
  localparam logic [4:0] OFS_ABT = 5'h0D;
  localparam logic [4:0] OFS_UND = 5'h0F;

  localparam int SAVED_STATUS_WORD_SLOTS = 5;
  localparam logic [2:0] SLOT_FIQ = 3'h0;
  localparam logic [2:0] SLOT_IRQ = 3'h1;
  localparam logic [2:0] SLOT_SVC = 3'h2;
  localparam logic [2:0] SLOT_ABT = 3'h3;
  localparam logic [2:0] SLOT_UND = 3'h4;
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // ---------------------------------------------------------------------------
  // System coprocessor
  // ---------------------------------------------------------------------------
  localparam logic [3:0] CP_SYS_NUM = 4'hF;
  localparam logic [3:0] CP_MULHI_REG = 4'hB;

  // ---------------------------------------------------------------------------
  // Undefined instruction space
  // ---------------------------------------------------------------------------
  localparam logic [2:0] UNDEF_OPC = 3'h3;
  localparam int UNDEF_OPC_LSB = 25;
  localparam int UNDEF_BIT = 4;

  // ---------------------------------------------------------------------------
  // Status word layout
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic [19:0] unused;
    logic irq_off;
    logic fiq_off;
    logic narrow;
    logic [4:0] mode;
  } status_s;

  localparam logic [31:0] STATUS_USED_MASK = 32'hF000_00FF;
  localparam logic [31:0] STATUS_FLAG_MASK = 32'hF000_0000;
  localparam status_s STATUS_RESET = '{n: 1'b0, z: 1'b0, c: 1'b0, v: 1'b0, unused: 20'h0_0000,
                                       irq_off: 1'b1, fiq_off: 1'b1, narrow: 1'b0, mode: MODE_SVC};

  // ---------------------------------------------------------------------------
  // Exception requests and the chosen one
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic data_abort;
    logic fast_interrupt;
    logic irq;
    logic prefetch_abort;
    logic undef;
    logic trap;
  } exc_req_s;

  typedef enum logic [6:0] {
    EXC_NONE = 7'h00,
    EXC_DABT = 7'h01,
    EXC_FIQ = 7'h02,
    EXC_IRQ = 7'h04,
    EXC_PABT = 7'h08,
    EXC_UNDEF = 7'h10,
    EXC_TRAP = 7'h20,
    EXC_RESET = 7'h40
  } exc_kind_e;

endpackage : banked_regs_pkg

// [rtl/exception_arbiter.sv]
// Fixed-priority selection among pending exception requests
`timescale 1ns/1ns
module exception_arbiter import banked_regs_pkg::*; (
  input wire exc_req_s i_req,
  output exc_kind_e o_kind
);

  always_comb begin
    if (i_req.data_abort) begin
      o_kind = EXC_DABT;
    end else if (i_req.fast_interrupt) begin
      o_kind = EXC_FIQ;
    end else if (i_req.irq) begin
      o_kind = EXC_IRQ;
    end else if (i_req.prefetch_abort) begin
      o_kind = EXC_PABT;
    end else if (i_req.undef) begin
      o_kind = EXC_UNDEF;
    end else if (i_req.trap) begin
      o_kind = EXC_TRAP;
    end else begin
      o_kind = EXC_NONE;
    end
  end

endmodule : exception_arbiter

// [tb/banked_regs_exception_unit_properties.sv]
// Port-level assertions for the banked register exception unit
`timescale 1ns/1ns
module banked_regs_exception_unit_properties import banked_regs_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_data_abort,
  input wire logic i_instr_valid,
  input wire logic [31:0] i_instr,
  input wire logic i_cp_instr,
  input wire logic [3:0] i_cp_num,
  input wire logic i_mul_valid,
  input wire logic [31:0] i_mul_hi,
  input wire logic i_cp_re,
  input wire logic i_cp_we,
  input wire logic [3:0] i_cp_reg,
  input wire logic [31:0] o_pc,
  input wire status_s o_status,
  input wire logic [31:0] o_saved_status,
  input wire logic [31:0] o_cp_rdata,
  input wire logic o_exc_taken,
  input wire exc_kind_e o_exc_kind
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_dabt_entry:
    assert property (i_data_abort |=> o_exc_taken && o_exc_kind == EXC_DABT && o_pc == VEC_DABT)
      else $error("data abort entry wrong");
  a_abort_mode:
    assert property (o_exc_kind inside {EXC_DABT, EXC_PABT} |-> o_status.mode == MODE_ABT)
      else $error("abort entry mode wrong");
  a_trap_vector:
    assert property (o_exc_kind == EXC_TRAP |-> o_pc == VEC_TRAP && o_status.mode == MODE_SVC)
      else $error("trap entry wrong");
  a_undef_vector:
    assert property (o_exc_kind == EXC_UNDEF |-> o_pc == VEC_UNDEF && o_status.mode == MODE_UND)
      else $error("undefined entry wrong");
  a_irq_gate:
    assert property (o_exc_kind == EXC_IRQ |-> !$past(o_status.irq_off) && o_pc == VEC_IRQ)
      else $error("normal interrupt entry wrong");
  a_fiq_gate:
    assert property (o_exc_kind == EXC_FIQ |-> !$past(o_status.fiq_off) && o_pc == VEC_FIQ)
      else $error("fast interrupt entry wrong");
  a_undef_detect:
    assert property (i_instr_valid && (i_instr[27:25] == UNDEF_OPC && i_instr[UNDEF_BIT]
      || i_cp_instr && i_cp_num != CP_SYS_NUM) |=> o_exc_taken) else $error("undefined not trapped");
  a_pc_halfword:
    assert property (o_pc[0] == 1'h0) else $error("pc bit 0 set");
  a_unused_zero:
    assert property (o_status.unused == 20'h0 && o_saved_status[27:8] == 20'h0)
      else $error("unused status bits set");
  a_reset_entry:
    assert property (o_exc_kind == EXC_RESET |-> o_pc == VEC_RESET && o_status.mode == MODE_SVC
      && o_status.irq_off && o_status.fiq_off) else $error("reset state wrong");
  a_mulhi_read:
    assert property (i_mul_valid ##1 (i_cp_re && !i_cp_we && !i_mul_valid && i_cp_num == CP_SYS_NUM
      && i_cp_reg == CP_MULHI_REG) |=> o_cp_rdata == $past(i_mul_hi, 2)) else $error("high word lost");
endmodule : banked_regs_exception_unit_properties

bind banked_regs_exception_unit banked_regs_exception_unit_properties u_props (.*);

// [tb/intr_source_model.sv]
// Outside interrupt sources driving the unit's request pins
`timescale 1ns/1ns
module intr_source_model (
  input wire logic i_clk,
  input wire logic i_irq_go,
  input wire logic i_fiq_go,
  output logic o_irq_req = 1'h0,
  output logic o_fiq_req = 1'h0
);
  // Levels held until the source is served; dedicated pins, so low when idle
  always @(negedge i_clk) begin
    o_irq_req <= i_irq_go;
    o_fiq_req <= i_fiq_go;
  end
endmodule : intr_source_model

// [tb/testbench.sv]
// Directed bench for the banked register exception unit
`timescale 1ns/1ns
module testbench import banked_regs_pkg::*;;
  logic i_clk, i_rstn, i_irq_req, i_fiq_req, i_data_abort, i_prefetch_abort, i_trap, i_instr_valid;
  logic i_cp_instr, i_wr_en, i_wr_restore, i_pc_step, i_flag_we, i_logical_op, i_alu_carry, i_alu_ovf;
  logic i_shift_carry, i_status_we, i_status_saved, i_exc_return, i_mul_valid, i_cp_we, i_cp_re;
  logic o_exc_taken, irq_go, fiq_go;
  logic [3:0] i_cp_num, i_rd_addr, i_wr_addr, i_cp_reg;
  logic [31:0] i_instr, i_mem_pc, i_next_pc, i_wr_data, i_result, i_status_data, i_mul_hi, i_cp_wdata;
  logic [31:0] o_rd_data, o_pc, o_saved_status, o_cp_rdata, o_exc_vector;
  status_s o_status;
  exc_kind_e o_exc_kind;
  int num_errors = 0;
  int checks = 0;

  banked_regs_exception_unit u_banked_regs_exception_unit (.*);
  intr_source_model u_intr_source_model (.i_clk(i_clk), .i_irq_go(irq_go), .i_fiq_go(fiq_go),
    .o_irq_req(i_irq_req), .o_fiq_req(i_fiq_req));

  initial begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [31:0] sw(input logic [4:0] m, input logic i = 1'h1, input logic f = 1'h1,
    input logic t = 1'h0);
    return {24'h0, i, f, t, m};
  endfunction : sw

  task automatic cyc(input int n = 1);
    repeat (n) @(negedge i_clk);
  endtask : cyc

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_wr_en = 1'h1; i_wr_addr = a; i_wr_data = d;
    cyc();
    i_wr_en = 1'h0;
  endtask : wr

  task automatic wst(input logic [31:0] d);
    i_status_we = 1'h1; i_status_data = d;
    cyc();
    i_status_we = 1'h0;
  endtask : wst

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    i_rd_addr = a;
    cyc();
    chk("rd_data", e, o_rd_data);
  endtask : rd

  // Bounded wait for entry; single-cycle requests dropped after each edge
  task automatic exc(input int n, input exc_kind_e k, input logic [31:0] v, input logic [4:0] m);
    for (int i = 0; i < n && o_exc_taken !== 1'h1; i++) begin
      cyc();
      {i_data_abort, i_prefetch_abort, i_trap, i_instr_valid, i_cp_instr, i_instr} = '0;
      i_cp_num = CP_SYS_NUM;
    end
    chk("exc_taken", 32'h1, o_exc_taken);
    if (o_exc_taken !== 1'h1) end_sim();
    chk("exc_kind", k, o_exc_kind);
    chk("exc_pc", v, o_pc);
    chk("exc_vector", v, o_exc_vector);
    chk("exc_mode", m, o_status.mode);
  endtask : exc

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_bank();
    wr(4'h8, 32'hA08);
    wr(REG_STACK, 32'hA0D);
    wst(sw(MODE_FIQ));
    wr(4'h8, 32'hF08);
    wr(REG_STACK, 32'hF0D);
    wst(sw(MODE_IRQ));
    rd(4'h8, 32'hA08);
    rd(REG_STACK, 32'h0);
    wst(sw(MODE_FIQ));
    rd(4'h8, 32'hF08);
    rd(REG_STACK, 32'hF0D);
    wst(sw(MODE_SVC));
    rd(REG_STACK, 32'hA0D);
    $display("test bank done");
  endtask : t_bank

  task automatic t_abort();
    wst(sw(MODE_SVC));
    i_mem_pc = 32'h100; i_data_abort = 1'h1;
    exc(1, EXC_DABT, VEC_DABT, MODE_ABT);
    rd(REG_LINK, 32'h108);
    chk("saved", sw(MODE_SVC), o_saved_status);
    i_exc_return = 1'h1;
    cyc();
    i_exc_return = 1'h0;
    chk("ret_pc", 32'h108, o_pc);
    chk("ret_status", sw(MODE_SVC), o_status);
    i_mem_pc = 32'h200; i_prefetch_abort = 1'h1;
    exc(1, EXC_PABT, VEC_PABT, MODE_ABT);
    rd(REG_LINK, 32'h204);
    i_wr_restore = 1'h1;
    wr(REG_PC, 32'h800);
    i_wr_restore = 1'h0;
    chk("restore", sw(MODE_SVC), o_status);
    i_pc_step = 1'h1;
    cyc();
    i_pc_step = 1'h0;
    chk("pc_step", 32'h804, o_pc);
    i_status_saved = 1'h1;
    wst(sw(MODE_ABT));
    i_status_saved = 1'h0;
    rd(REG_PC, 32'h804);
    chk("saved_wr", sw(MODE_ABT), o_saved_status);
    $display("test abort done");
  endtask : t_abort

  task automatic t_sync(input int sel, input logic t);
    wst(sw(MODE_SVC, 1'h1, 1'h1, t));
    wr(REG_PC, 32'h1233);
    chk("pc_mask", t ? 32'h1232 : 32'h1230, o_pc);
    i_mem_pc = 32'h300; i_instr_valid = 1'h1;
    if (sel == 0) begin
      i_trap = 1'h1;
      exc(1, EXC_TRAP, VEC_TRAP, MODE_SVC);
    end else begin
      if (sel == 1) i_instr = 32'h0600_0010;
      else {i_cp_instr, i_cp_num} = {1'h1, 4'h3};
      exc(1, EXC_UNDEF, VEC_UNDEF, MODE_UND);
    end
    rd(REG_LINK, 32'h300 + (t ? LINK_OFS_2 : LINK_OFS_4));
    $display("test sync %0d done", sel);
  endtask : t_sync

  task automatic t_flags();
    i_flag_we = 1'h1; i_result = 32'h8000_0000; i_alu_carry = 1'h1; i_alu_ovf = 1'h1;
    cyc();
    chk("flags", 32'hB, o_status[31:28]);
    i_logical_op = 1'h1; i_result = 32'h0; i_alu_ovf = 1'h0;
    cyc();
    chk("flags_logic", 32'h5, o_status[31:28]);
    {i_flag_we, i_logical_op} = '0;
    $display("test flags done");
  endtask : t_flags

  task automatic t_mul();
    i_mul_valid = 1'h1; i_mul_hi = 32'hDEADBEEF;
    cyc();
    i_mul_valid = 1'h0; i_cp_re = 1'h1; i_cp_reg = CP_MULHI_REG;
    cyc();
    chk("mul_hi", 32'hDEADBEEF, o_cp_rdata);
    i_cp_reg = 4'h5;
    cyc();
    chk("cp_rsvd", 32'h0, o_cp_rdata);
    {i_cp_re, i_cp_we, i_cp_reg, i_cp_wdata} = {2'h1, CP_MULHI_REG, 32'h1234ABCD};
    cyc();
    {i_cp_re, i_cp_we} = 2'h2;
    cyc();
    chk("cp_write", 32'h1234ABCD, o_cp_rdata);
    i_cp_re = 1'h0;
    $display("test coprocessor done");
  endtask : t_mul

  task automatic t_intr();
    i_next_pc = 32'h500;
    {irq_go, fiq_go} = 2'h3;
    repeat (6) begin
      cyc();
      chk("masked", 32'h0, o_exc_taken);
    end
    wst(sw(MODE_SVC, 1'h0));
    exc(8, EXC_IRQ, VEC_IRQ, MODE_IRQ);
    {irq_go, fiq_go} = 2'h0;
    rd(REG_LINK, 32'h504);
    cyc(3);
    i_next_pc = 32'h600;
    wst(sw(MODE_SVC, 1'h0, 1'h0));
    {irq_go, fiq_go} = 2'h3;
    exc(8, EXC_FIQ, VEC_FIQ, MODE_FIQ);
    {irq_go, fiq_go} = 2'h0;
    rd(REG_LINK, 32'h604);
    $display("test interrupts done");
  endtask : t_intr

  task automatic t_user();
    logic [4:0] m;
    for (int j = 0; j < 2; j++) begin
      m = j ? MODE_SYS : MODE_USR;
      wst(sw(m));
      cyc();
      chk("user_saved", 32'h0, o_saved_status);
      wst(32'hFFFF_FF13);
      chk("user_status", 32'hF000_0000 | sw(m), o_status);
      i_data_abort = 1'h1;
      exc(1, EXC_DABT, VEC_DABT, MODE_ABT);
    end
    $display("test user done");
  endtask : t_user

  initial begin
    i_rstn = 1'h0;
    {i_data_abort, i_prefetch_abort, i_trap, i_instr_valid, i_cp_instr, i_wr_en, i_wr_restore, i_pc_step,
      i_flag_we, i_logical_op, i_alu_carry, i_alu_ovf, i_shift_carry, i_status_we, i_status_saved,
      i_exc_return, i_mul_valid, i_cp_we, i_cp_re, irq_go, fiq_go} = '0;
    {i_rd_addr, i_wr_addr, i_cp_reg, i_instr, i_mem_pc, i_next_pc, i_wr_data, i_result, i_status_data,
      i_mul_hi, i_cp_wdata} = '0;
    i_cp_num = CP_SYS_NUM;
    cyc(2);
    i_rstn = 1'h1;
    chk("rst_pc", VEC_RESET, o_pc);
    chk("rst_status", sw(MODE_SVC), o_status);
    chk("rst_kind", EXC_RESET, o_exc_kind);
    t_bank();
    t_abort();
    for (int s = 0; s < 6; s++) t_sync(s % 3, 1'(s / 3));
    t_flags();
    t_mul();
    t_intr();
    t_user();
    end_sim();
  end
endmodule : testbench
